//--- hw/rbia_agen.sv
/*
  Register-bit indirect address generator: forms the bit address from an
  extended auxiliary pointer, updates the pointer and performs bit operations.
  Assumes the pipeline presents one operation per cycle with the selected
  pointer, its circular-enable bit and buffer start value already muxed.
*/
`timescale 1ns/10ps
`include "rbia_cfg.svh"

// Function
// - post-decrement: use pointer, then subtract step
// - bit pair touches address and address plus one
// - pair test copies low/high bits to flags
// - bit set changes only the addressed bit
// - pre-increment address is pointer plus step
// - pre-increment writes incremented pointer back
// - pre-decrement subtracts step, uses reduced value
// - indexed post-increment adds mode-selected index
// - circular pointer adds sign-extended buffer start
// - only accumulators, auxiliaries, temporaries are targets
module rbia_agen (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // operation request
  input wire logic op_valid_i,
  input wire rbia_pkg::rbia_mode_e op_mode_i,
  input wire rbia_pkg::rbia_op_e op_kind_i,
  input wire logic op_pair_i,
  input wire logic [`RBIA_TGT_W-1:0] target_sel_i,
  input wire logic [`RBIA_DATA_W-1:0] target_data_i,
  // pointer and addressing configuration
  input wire logic [`RBIA_PTR_W-1:0] extended_aux_pointer_i,
  input wire logic circular_enable_i,
  input wire logic [`RBIA_LOW_W-1:0] buffer_start_offset_i,
  input wire logic legacy_compat_mode_i,
  input wire logic [`RBIA_LOW_W-1:0] temp_index_reg_i,
  input wire logic [`RBIA_PTR_W-1:0] extended_aux_index_reg_i,
  // completion
  output logic done_o,
  output logic illegal_o,
  output logic [`RBIA_PTR_W-1:0] bit_addr_o,
  // pointer write-back
  output logic ptr_we_o,
  output logic [`RBIA_PTR_W-1:0] extended_aux_pointer_o,
  // target write-back
  output logic data_we_o,
  output logic [`RBIA_DATA_W-1:0] data_o,
  // status register test flags, loaded with the values of the tested bits
  output logic flag_we_o,
  output logic test_flag_first_o,
  output logic test_flag_second_o
);
  import rbia_pkg::*;

  logic [`RBIA_PTR_W-1:0] step;
  logic [`RBIA_PTR_W-1:0] offs;
  logic [`RBIA_PTR_W-1:0] index_ext;
  logic [`RBIA_PTR_W-1:0] base;
  logic [`RBIA_PTR_W-1:0] ptr_next;
  logic [`RBIA_PTR_W-1:0] addr_next;
  logic [`RBIA_PTR_W-1:0] addr_hi;
  logic legal;
  logic wide;
  logic [`RBIA_DATA_W-1:0] lane0_data;
  logic [`RBIA_DATA_W-1:0] lane1_data;
  logic lane0_bit;
  logic lane1_bit;
  logic accept;
  logic done_reg;
  logic illegal_reg;
  logic [`RBIA_PTR_W-1:0] bit_addr_reg;
  logic ptr_we_reg;
  logic [`RBIA_PTR_W-1:0] ptr_reg;
  logic data_we_reg;
  logic [`RBIA_DATA_W-1:0] data_reg;
  logic flag_we_reg;
  logic flag_first_reg;
  logic flag_second_reg;

  // step and index; the short index is taken as signed, like an offset
  assign step = op_pair_i ? `RBIA_STEP_TWO : `RBIA_STEP_ONE;
  assign index_ext = legacy_compat_mode_i ? extended_aux_index_reg_i
                                          : {{7{temp_index_reg_i[15]}}, temp_index_reg_i};
  assign offs = circular_enable_i ? {{7{buffer_start_offset_i[15]}}, buffer_start_offset_i}
                                  : `RBIA_PTR_ZERO;

  // target class check; the codes above the temporaries hold no register
  assign legal = (target_sel_i <= `RBIA_TGT_TMP_LAST);
  assign wide = (target_sel_i <= `RBIA_TGT_ACC_LAST);
  assign accept = op_valid_i && legal;

  // address base and pointer update per mode, full width, no wrap care
  always_comb begin
    base = extended_aux_pointer_i;
    ptr_next = extended_aux_pointer_i;
    case (op_mode_i)
      RBIA_MODE_POST_DEC: begin
        ptr_next = extended_aux_pointer_i - step;
      end
      RBIA_MODE_PRE_INC: begin
        base = extended_aux_pointer_i + step;
        ptr_next = extended_aux_pointer_i + step;
      end
      RBIA_MODE_PRE_DEC: begin
        base = extended_aux_pointer_i - step;
        ptr_next = extended_aux_pointer_i - step;
      end
      default: begin
        ptr_next = extended_aux_pointer_i + index_ext;
      end
    endcase
  end

  // bit address and its pair partner
  assign addr_next = base + offs;
  assign addr_hi = addr_next + `RBIA_STEP_ONE;

  // two chained lanes so a pair operation sees both bits
  rbia_bit_unit u_lane0 (
    .data_i(target_data_i),
    .index_i(addr_next[`RBIA_IDX_W-1:0]),
    .wide_i(wide),
    .kind_i(op_kind_i),
    .data_o(lane0_data),
    .bit_o(lane0_bit)
  );

  rbia_bit_unit u_lane1 (
    .data_i(lane0_data),
    .index_i(addr_hi[`RBIA_IDX_W-1:0]),
    .wide_i(wide),
    .kind_i(op_kind_i),
    .data_o(lane1_data),
    .bit_o(lane1_bit)
  );

  // completion and refusal, one-cycle pulses
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      done_reg <= 1'b0;
      illegal_reg <= 1'b0;
      bit_addr_reg <= '0;
    end else begin
      done_reg <= op_valid_i;
      illegal_reg <= op_valid_i && !legal;
      if (op_valid_i) begin
        bit_addr_reg <= addr_next;
      end
    end
  end

  // pointer write-back; refused operations leave the pointer alone
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ptr_we_reg <= 1'b0;
      ptr_reg <= '0;
    end else begin
      ptr_we_reg <= accept;
      if (accept) begin
        ptr_reg <= ptr_next;
      end
    end
  end

  // target write-back for set, clear and complement
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      data_we_reg <= 1'b0;
      data_reg <= '0;
    end else begin
      data_we_reg <= accept && (op_kind_i != RBIA_OP_TEST);
      if (accept) begin
        data_reg <= op_pair_i ? lane1_data : lane0_data;
      end
    end
  end

  // test flags; a single test loads the first flag only
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flag_we_reg <= 1'b0;
      flag_first_reg <= 1'b0;
      flag_second_reg <= 1'b0;
    end else begin
      flag_we_reg <= accept && (op_kind_i == RBIA_OP_TEST);
      if (accept && (op_kind_i == RBIA_OP_TEST)) begin
        flag_first_reg <= lane0_bit;
        if (op_pair_i) begin
          flag_second_reg <= lane1_bit;
        end
      end
    end
  end

  assign done_o = done_reg;
  assign illegal_o = illegal_reg;
  assign bit_addr_o = bit_addr_reg;
  assign ptr_we_o = ptr_we_reg;
  assign extended_aux_pointer_o = ptr_reg;
  assign data_we_o = data_we_reg;
  assign data_o = data_reg;
  assign flag_we_o = flag_we_reg;
  assign test_flag_first_o = flag_first_reg;
  assign test_flag_second_o = flag_second_reg;

  // checker copies of the request, read by the properties only
  logic [`RBIA_DATA_W-1:0] chk_data_reg;
  logic chk_pair_reg;
  logic chk_wide_reg;
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      chk_data_reg <= '0;
      chk_pair_reg <= 1'b0;
      chk_wide_reg <= 1'b0;
    end else begin
      chk_data_reg <= target_data_i;
      chk_pair_reg <= op_pair_i;
      chk_wide_reg <= wide;
    end
  end

  // pointer and address relations per mode
  property p_post_dec_ptr;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      accept && op_mode_i == RBIA_MODE_POST_DEC |=>
        ptr_we_o && extended_aux_pointer_o == $past(extended_aux_pointer_i) - (chk_pair_reg ? 23'h2 : 23'h1);
  endproperty
  a_post_dec_ptr: assert property (p_post_dec_ptr) else $error("post-decrement pointer wrong");

  property p_post_dec_addr;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      accept && op_mode_i == RBIA_MODE_POST_DEC |=> bit_addr_o == $past(extended_aux_pointer_i) + $past(offs);
  endproperty
  a_post_dec_addr: assert property (p_post_dec_addr) else $error("post-decrement address wrong");

  property p_pre_inc;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      accept && op_mode_i == RBIA_MODE_PRE_INC |=>
        bit_addr_o == extended_aux_pointer_o + $past(offs) &&
        extended_aux_pointer_o == $past(extended_aux_pointer_i) + (chk_pair_reg ? 23'h2 : 23'h1);
  endproperty
  a_pre_inc: assert property (p_pre_inc) else $error("pre-increment address or pointer wrong");

  property p_pre_dec;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      accept && op_mode_i == RBIA_MODE_PRE_DEC |=>
        bit_addr_o == extended_aux_pointer_o + $past(offs) &&
        extended_aux_pointer_o == $past(extended_aux_pointer_i) - (chk_pair_reg ? 23'h2 : 23'h1);
  endproperty
  a_pre_dec: assert property (p_pre_dec) else $error("pre-decrement address or pointer wrong");

  property p_idx_post_inc;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      accept && op_mode_i == RBIA_MODE_IDX_POST_INC |=>
        bit_addr_o == $past(extended_aux_pointer_i) + $past(offs) &&
        extended_aux_pointer_o == $past(extended_aux_pointer_i) + $past(index_ext);
  endproperty
  a_idx_post_inc: assert property (p_idx_post_inc) else $error("indexed post-increment wrong");

  property p_linear_no_offset;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      accept && !circular_enable_i && op_mode_i == RBIA_MODE_POST_DEC |=>
        bit_addr_o == $past(extended_aux_pointer_i);
  endproperty
  a_linear_no_offset: assert property (p_linear_no_offset) else $error("offset added without circular mode");

  // pair test flags against the captured target word
  property p_pair_flags;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      flag_we_o && chk_pair_reg && chk_wide_reg && bit_addr_o[5:0] < (`RBIA_WIDE_BITS - 6'h01) |->
        test_flag_first_o == chk_data_reg[bit_addr_o[5:0]] &&
        test_flag_second_o == chk_data_reg[bit_addr_o[5:0] + 6'h01];
  endproperty
  a_pair_flags: assert property (p_pair_flags) else $error("pair test flags wrong");

  property p_single_set;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      accept && op_kind_i == RBIA_OP_SET && !op_pair_i && wide && addr_next[5:0] < `RBIA_WIDE_BITS |=>
        data_we_o && data_o == (chk_data_reg | (`RBIA_DATA_W'(1) << bit_addr_o[5:0]));
  endproperty
  a_single_set: assert property (p_single_set) else $error("bit set touched wrong bits");

  property p_illegal_target;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      op_valid_i && !legal |=> illegal_o && !ptr_we_o && !data_we_o && !flag_we_o;
  endproperty
  a_illegal_target: assert property (p_illegal_target) else $error("illegal target not refused");

  property p_ptr_we_cause;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      ptr_we_o |-> done_o && !illegal_o && $past(op_valid_i);
  endproperty
  a_ptr_we_cause: assert property (p_ptr_we_cause) else $error("pointer written without operation");

  // main scenarios
  c_pair_test: cover property (@(posedge core_clk_i) disable iff (!reset_n_i) flag_we_o && chk_pair_reg);
  c_pre_inc_set: cover property (@(posedge core_clk_i) disable iff (!reset_n_i)
    accept && op_mode_i == RBIA_MODE_PRE_INC && op_kind_i == RBIA_OP_SET);
  c_idx_legacy: cover property (@(posedge core_clk_i) disable iff (!reset_n_i)
    accept && op_mode_i == RBIA_MODE_IDX_POST_INC && legacy_compat_mode_i);
  c_illegal: cover property (@(posedge core_clk_i) disable iff (!reset_n_i) illegal_o);
endmodule

//--- common/rbia_cfg.svh
/*
  Constants for the register-bit indirect address generator.
  Assumes inclusion by bare name from any file that needs widths or codes.
*/
`ifndef RBIA_CFG_SVH
`define RBIA_CFG_SVH

// widths of the extended pointer, its low part and the data path
`define RBIA_PTR_W 23
`define RBIA_LOW_W 16
`define RBIA_DATA_W 40
`define RBIA_IDX_W 6
`define RBIA_TGT_W 5

// pointer steps for single-bit and bit-pair operations
`define RBIA_STEP_ONE 23'h000001
`define RBIA_STEP_TWO 23'h000002
`define RBIA_PTR_ZERO 23'h000000

// target register codes: accumulators, auxiliaries, temporaries
`define RBIA_TGT_ACC_LAST 5'h03
`define RBIA_TGT_TMP_LAST 5'h0F

// usable bit counts of wide and narrow targets
`define RBIA_WIDE_BITS 6'h28
`define RBIA_NARROW_BITS 6'h10

`endif

//--- common/rbia_pkg.sv
/*
  Types for the register-bit indirect address generator.
  Assumes the constants header is compiled alongside.
*/
package rbia_pkg;

  // indirect addressing modes carried by this unit
  typedef enum logic [1:0] {
    RBIA_MODE_POST_DEC,
    RBIA_MODE_PRE_INC,
    RBIA_MODE_PRE_DEC,
    RBIA_MODE_IDX_POST_INC
  } rbia_mode_e;

  // register-bit operations
  typedef enum logic [1:0] {
    RBIA_OP_TEST,
    RBIA_OP_SET,
    RBIA_OP_CLEAR,
    RBIA_OP_COMPL
  } rbia_op_e;

endpackage

//--- hw/rbia_bit_unit.sv
/*
  One bit lane: reads a single bit of a target word and applies a bit operation.
  Assumes the caller supplies an index already reduced to the lane width.
*/
`timescale 1ns/10ps
`include "rbia_cfg.svh"

module rbia_bit_unit (
  // operand
  input wire logic [`RBIA_DATA_W-1:0] data_i,
  input wire logic [`RBIA_IDX_W-1:0] index_i,
  input wire logic wide_i,
  input wire rbia_pkg::rbia_op_e kind_i,
  // result
  output logic [`RBIA_DATA_W-1:0] data_o,
  output logic bit_o
);
  import rbia_pkg::*;

  logic in_range;
  logic [`RBIA_DATA_W-1:0] mask;

  // bits past the register width read as zero and are never touched
  assign in_range = (index_i < (wide_i ? `RBIA_WIDE_BITS : `RBIA_NARROW_BITS));
  assign mask = in_range ? (`RBIA_DATA_W'(1) << index_i) : '0;

  // only the addressed bit changes, all others pass unchanged
  always_comb begin
    bit_o = |(data_i & mask);
    case (kind_i)
      RBIA_OP_SET: data_o = data_i | mask;
      RBIA_OP_CLEAR: data_o = data_i & ~mask;
      RBIA_OP_COMPL: data_o = data_i ^ mask;
      default: data_o = data_i;
    endcase
  end
endmodule

//--- dv/tb_top.sv
/*
  Self-checking bench for the register-bit indirect address generator.
  Assumes the design files, package and constants header are compiled first.
*/
`timescale 1ns/10ps
`include "rbia_cfg.svh"

module tb_top;
  import rbia_pkg::*;

  typedef struct packed {
    logic ill; logic pwe; logic dwe; logic fwe;
    logic [22:0] addr; logic [22:0] ptr; logic [39:0] data; logic f1; logic f2;
  } rbia_exp_s;

  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic vld = 1'b0;
  rbia_mode_e mode = RBIA_MODE_POST_DEC;
  rbia_op_e kind = RBIA_OP_TEST;
  logic pair = 1'b0;
  logic [4:0] tgt = 5'h00;
  logic [39:0] tdata = 40'h0;
  logic [22:0] ptr_in = 23'h0;
  logic circ = 1'b0;
  logic [15:0] bso = 16'h0;
  logic compat = 1'b0;
  logic [15:0] tidx = 16'h0;
  logic [22:0] xidx = 23'h0;
  logic done, ill, pwe, dwe, fwe, f1, f2;
  logic [22:0] addr, ptr_out;
  logic [39:0] dout;
  rbia_exp_s expq[$];
  logic mf1 = 1'b0;
  logic mf2 = 1'b0;
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;
  integer seed = 17998;

  rbia_agen i_rbia_agen (
    .core_clk_i(clk), .reset_n_i(reset_n), .op_valid_i(vld), .op_mode_i(mode), .op_kind_i(kind),
    .op_pair_i(pair), .target_sel_i(tgt), .target_data_i(tdata), .extended_aux_pointer_i(ptr_in),
    .circular_enable_i(circ), .buffer_start_offset_i(bso), .legacy_compat_mode_i(compat),
    .temp_index_reg_i(tidx), .extended_aux_index_reg_i(xidx), .done_o(done), .illegal_o(ill),
    .bit_addr_o(addr), .ptr_we_o(pwe), .extended_aux_pointer_o(ptr_out), .data_we_o(dwe),
    .data_o(dout), .flag_we_o(fwe), .test_flag_first_o(f1), .test_flag_second_o(f2)
  );

  // 100 MHz clock
  always #5 clk = ~clk;

  // bits past the target width read as zero and are never changed
  function automatic logic rdb(input logic [39:0] v, input logic [5:0] i, input logic w);
    return (i < (w ? `RBIA_WIDE_BITS : `RBIA_NARROW_BITS)) ? v[i] : 1'b0;
  endfunction

  function automatic logic [39:0] flip(input logic [39:0] v, input logic [5:0] i, input logic w,
                                       input rbia_op_e k);
    if (i >= (w ? `RBIA_WIDE_BITS : `RBIA_NARROW_BITS)) return v;
    case (k)
      RBIA_OP_SET: v[i] = 1'b1;
      RBIA_OP_CLEAR: v[i] = 1'b0;
      default: v[i] = ~v[i];
    endcase
    return v;
  endfunction

  task automatic chk_bit(input logic got, input logic exp, input string what);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic chk_val(input logic [39:0] got, input logic [39:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // drive one request at a rising edge and note what the design must answer
  task automatic op(input rbia_mode_e m, input rbia_op_e k, input logic p, input logic [4:0] t,
                    input logic [39:0] d, input logic [22:0] pt, input logic c, input logic [15:0] b,
                    input logic cm, input logic [15:0] ti, input logic [22:0] xi);
    rbia_exp_s e;
    logic [22:0] st, off;
    logic [5:0] b0, b1;
    logic wd;
    @(posedge clk);
    vld <= 1'b1; mode <= m; kind <= k; pair <= p; tgt <= t; tdata <= d; ptr_in <= pt;
    circ <= c; bso <= b; compat <= cm; tidx <= ti; xidx <= xi;
    st = p ? `RBIA_STEP_TWO : `RBIA_STEP_ONE;
    off = c ? {{7{b[15]}}, b} : `RBIA_PTR_ZERO;
    case (m)
      RBIA_MODE_POST_DEC: begin e.addr = pt + off; e.ptr = pt - st; end
      RBIA_MODE_PRE_INC: begin e.ptr = pt + st; e.addr = e.ptr + off; end
      RBIA_MODE_PRE_DEC: begin e.ptr = pt - st; e.addr = e.ptr + off; end
      default: begin e.addr = pt + off; e.ptr = pt + (cm ? xi : {{7{ti[15]}}, ti}); end
    endcase
    e.ill = t > `RBIA_TGT_TMP_LAST;
    wd = t <= `RBIA_TGT_ACC_LAST;
    b0 = e.addr[5:0];
    b1 = b0 + 6'h01;
    e.pwe = !e.ill;
    e.dwe = !e.ill && k != RBIA_OP_TEST;
    e.fwe = !e.ill && k == RBIA_OP_TEST;
    e.data = d;
    if (e.dwe) begin
      e.data = flip(e.data, b0, wd, k);
      if (p) e.data = flip(e.data, b1, wd, k);
    end
    if (e.fwe) begin
      mf1 = rdb(d, b0, wd);
      if (p) mf2 = rdb(d, b1, wd);
    end
    e.f1 = mf1;
    e.f2 = mf2;
    expq.push_back(e);
  endtask

  // watcher: each done pulse retires the oldest note
  always @(negedge clk) begin
    rbia_exp_s e;
    if (reset_n && done === 1'b1) begin
      if (expq.size() == 0) begin
        n_mismatch++;
        $display("[FAIL] %0t done without request", $time);
      end else begin
        e = expq.pop_front();
        chk_bit(ill, e.ill, "illegal");
        chk_bit(pwe, e.pwe, "pointer write");
        chk_bit(dwe, e.dwe, "data write");
        chk_bit(fwe, e.fwe, "flag write");
        chk_val({17'h0, addr}, {17'h0, e.addr}, "bit address");
        if (e.pwe) chk_val({17'h0, ptr_out}, {17'h0, e.ptr}, "pointer");
        if (e.dwe) chk_val(dout, e.data, "target data");
        if (e.fwe) chk_bit(f1, e.f1, "first flag");
        if (e.fwe) chk_bit(f2, e.f2, "second flag");
      end
    end
  end

  // hang guard, far above the few hundred cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    if (n_mismatch == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    logic [4:0] rt;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    chk_bit(done, 1'b0, "done after reset");
    op(RBIA_MODE_POST_DEC, RBIA_OP_TEST, 1'b1, 5'h03, 40'h0080000000, 23'h00001E, 1'b0, 16'h0, 1'b0, 16'h0, 23'h0);
    op(RBIA_MODE_POST_DEC, RBIA_OP_SET, 1'b0, 5'h02, 40'h0, 23'h000005, 1'b0, 16'h0, 1'b0, 16'h0, 23'h0);
    op(RBIA_MODE_PRE_INC, RBIA_OP_SET, 1'b0, 5'h03, 40'h0, 23'h000000, 1'b0, 16'h0, 1'b0, 16'h0, 23'h0);
    op(RBIA_MODE_PRE_INC, RBIA_OP_TEST, 1'b1, 5'h00, 40'h00C0000000, 23'h00001C, 1'b0, 16'h0, 1'b0, 16'h0, 23'h0);
    op(RBIA_MODE_PRE_DEC, RBIA_OP_CLEAR, 1'b1, 5'h00, 40'hFFFFFFFFFF, 23'h000020, 1'b0, 16'h0, 1'b0, 16'h0, 23'h0);
    op(RBIA_MODE_PRE_DEC, RBIA_OP_COMPL, 1'b0, 5'h08, 40'h000000AAAA, 23'h000004, 1'b0, 16'h0, 1'b0, 16'h0, 23'h0);
    op(RBIA_MODE_IDX_POST_INC, RBIA_OP_COMPL, 1'b0, 5'h0C, 40'h000000FFFF, 23'h000005, 1'b0, 16'h0, 1'b0, 16'hFFFE, 23'h000100);
    op(RBIA_MODE_IDX_POST_INC, RBIA_OP_TEST, 1'b0, 5'h0F, 40'h0000000020, 23'h000005, 1'b0, 16'h0, 1'b1, 16'hFFFE, 23'h000100);
    op(RBIA_MODE_POST_DEC, RBIA_OP_TEST, 1'b1, 5'h01, 40'h0000000008, 23'h00000A, 1'b1, 16'hFFF8, 1'b0, 16'h0, 23'h0);
    op(RBIA_MODE_PRE_INC, RBIA_OP_SET, 1'b0, 5'h02, 40'h0, 23'h000004, 1'b1, 16'h0020, 1'b0, 16'h0, 23'h0);
    op(RBIA_MODE_PRE_INC, RBIA_OP_SET, 1'b1, 5'h04, 40'h0000001234, 23'h7F0010, 1'b0, 16'h0, 1'b0, 16'h0, 23'h0);
    op(RBIA_MODE_PRE_DEC, RBIA_OP_TEST, 1'b0, 5'h03, 40'h8000000000, 23'h000029, 1'b0, 16'h0, 1'b0, 16'h0, 23'h0);
    for (int t = 16; t < 32; t += 5) begin
      op(RBIA_MODE_PRE_INC, RBIA_OP_SET, 1'b0, 5'(t), 40'h0, 23'h000003, 1'b0, 16'h0, 1'b0, 16'h0, 23'h0);
    end
    // random back-to-back traffic; narrow targets keep upper data bits clear
    for (int i = 0; i < 300; i++) begin
      rt = 5'($random(seed));
      op(rbia_mode_e'(2'($random(seed))), rbia_op_e'(2'($random(seed))), 1'($random(seed)), rt,
         (rt <= 5'h03) ? 40'($random(seed)) << 8 ^ 40'($random(seed)) : 40'($random(seed) & 32'hFFFF),
         23'($random(seed)), 1'($random(seed)), 16'($random(seed)), 1'($random(seed)),
         16'($random(seed)), 23'($random(seed)));
    end
    @(posedge clk);
    vld <= 1'b0;
    repeat (4) @(posedge clk);
    chk_val(40'(expq.size()), 40'h0, "answers missing");
    // mid-run reset: held outputs and the flag model return to zero
    reset_n <= 1'b0;
    mf1 = 1'b0;
    mf2 = 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    chk_val(40'({done, ill, pwe, dwe, fwe, f1, f2}), 40'h0, "pulses or flags after reset");
    chk_val({17'h0, addr}, 40'h0, "address after reset");
    chk_val({17'h0, ptr_out}, 40'h0, "pointer after reset");
    chk_val(dout, 40'h0, "data after reset");
    op(RBIA_MODE_POST_DEC, RBIA_OP_TEST, 1'b0, 5'h03, 40'h0000000001, 23'h000000, 1'b0, 16'h0, 1'b0, 16'h0, 23'h0);
    @(posedge clk);
    vld <= 1'b0;
    repeat (4) @(posedge clk);
    chk_val(40'(expq.size()), 40'h0, "answers missing after reset");
    wrap_up();
  end
endmodule
